//--- pwr_defines.svh
// Constants for the power mode controller: offsets, fields, reset values, timing counts
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

// Register byte offsets
`define REG_CTRL        12'h000
`define REG_ACT_TMPL    12'h004
`define REG_ALT_TMPL    12'h008
`define REG_WAKE_MASK   12'h00c
`define REG_STATUS      12'h010

// Control register fields
`define CTRL_REQ_LSB    0
`define CTRL_CPU_OFF    4

// Mode request codes written to the control register
`define REQ_ALT         3'h1
`define REQ_SLEEP       3'h2
`define REQ_HIB         3'h4

// Reset values
`define ACT_TMPL_RST    32'hffffffff
`define ALT_TMPL_RST    32'h00000000
`define WAKE_MASK_RST   32'hffffffff

// Subsystems always kept alive in sleep: bit 1 only, the sleep timer; bit 0 is the CPU, off in sleep
`define CPU_BIT         0
`define SLEEP_KEEP      32'h00000002

// Wakeup timing
`define CLK_HZ          20000000
`define SLEEP_WAKE_NS   15000
`define HIB_WAKE_NS     100000
`define SLEEP_WAKE_CYC  ((`SLEEP_WAKE_NS * (`CLK_HZ / 1000000)) / 1000)
`define HIB_WAKE_CYC    ((`HIB_WAKE_NS * (`CLK_HZ / 1000000)) / 1000 - 1)

`endif

//--- pwr_pkg.sv
// Types for the power mode controller
package pwr_pkg;
    typedef enum logic [4:0] {
        ST_ACTIVE = 5'b00001,
        ST_ALT    = 5'b00010,
        ST_SLEEP  = 5'b00100,
        ST_HIB    = 5'b01000,
        ST_RESUME = 5'b10000
    } mode_t;
endpackage : pwr_pkg

//--- wake_timer.sv
// Resume delay counter used while regulators come back up
`timescale 1ns/1ns
module wake_timer #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // Status
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;

    // Count down from the load value, one pulse of done at the end
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done  = 1'b0;
        if (start) begin
            cnt_d = load;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_d = 1'b0;
                done  = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule : wake_timer

//--- power_mode_controller.sv
// Global power mode controller with AXI4-Lite register access
`timescale 1ns/1ns
`include "pwr_defines.svh"
module power_mode_controller #(
    parameter int NSUB = 8,
    parameter int NIRQ = 8
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // AXI4-Lite write address and data
    input  wire logic [11:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Wakeup sources
    input  wire logic [NIRQ-1:0] irq_wake,
    input  wire logic            pin_interrupt_unit,
    input  wire logic            external_reset_pin,
    input  wire logic            watchdog_reset,
    input  wire logic            precise_supply_reset,
    // Subsystem controls
    output logic [NSUB-1:0]      sub_enable,
    output logic [NSUB-1:0]      sub_clk_en,
    output logic                 cpu_enable,
    output logic                 clocks_run,
    output logic                 gpio_hold,
    output logic                 reg_enable,
    output logic [4:0]           mode_state
);
    localparam logic [31:0] ACT_RST = `ACT_TMPL_RST;
    localparam logic [31:0] ALT_RST = `ALT_TMPL_RST;
    localparam logic [31:0] MSK_RST = `WAKE_MASK_RST;
    localparam logic [31:0] KEEP    = `SLEEP_KEEP;
    localparam logic [11:0] SLP_CYC = 12'(`SLEEP_WAKE_CYC);
    localparam logic [11:0] HIB_CYC = 12'(`HIB_WAKE_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Known register decode, shared by read and write paths
    function automatic logic mapped(input logic [11:0] a);
        return a == `REG_CTRL || a == `REG_ACT_TMPL || a == `REG_ALT_TMPL ||
               a == `REG_WAKE_MASK || a == `REG_STATUS;
    endfunction : mapped

    logic [11:0]     awaddr_q, awaddr_d;
    logic            aw_have_q, aw_have_d;
    logic [31:0]     wdata_q, wdata_d;
    logic [3:0]      wstrb_q, wstrb_d;
    logic            w_have_q, w_have_d;
    logic            bvalid_q, bvalid_d;
    logic [1:0]      bresp_q, bresp_d;
    logic            rvalid_q, rvalid_d;
    logic [1:0]      rresp_q, rresp_d;
    logic [31:0]     rdata_q, rdata_d;
    logic            wr_fire;
    logic [31:0]     act_q, act_d;
    logic [31:0]     alt_q, alt_d;
    logic [31:0]     msk_q, msk_d;
    logic            cpu_off_q, cpu_off_d;
    logic [2:0]      req_pulse;

    pwr_pkg::mode_t  st_q, st_d;

    // Address and data may arrive in either order; one write in flight at a time
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

    always_comb begin
        awaddr_d  = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d  = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
            w_have_d = 1'b1;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(awaddr_q) ? 2'h0 : 2'h2;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                `REG_CTRL:      rdata_d = {27'h0, cpu_off_q, 4'h0};
                `REG_ACT_TMPL:  rdata_d = act_q;
                `REG_ALT_TMPL:  rdata_d = alt_q;
                `REG_WAKE_MASK: rdata_d = msk_q;
                `REG_STATUS:    rdata_d = {27'h0, st_q};
                default:        rdata_d = 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awaddr_q  <= 12'h0;
            aw_have_q <= 1'b0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0;
        end else begin
            awaddr_q  <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            w_have_q  <= w_have_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic wake_any;
    logic rst_wake;
    logic ctrl_wr;

    assign ctrl_wr   = wr_fire && awaddr_q == `REG_CTRL && wstrb_q[0];
    assign req_pulse = ctrl_wr ? wdata_q[`CTRL_REQ_LSB +: 3] : 3'h0;

    // Templates are written live; new bits reach sub_enable two cycles after the write
    always_comb begin
        act_d     = act_q;
        alt_d     = alt_q;
        msk_d     = msk_q;
        cpu_off_d = cpu_off_q;
        if (wr_fire && awaddr_q == `REG_ACT_TMPL) begin
            act_d = merge(act_q, wdata_q, wstrb_q);
        end
        if (wr_fire && awaddr_q == `REG_ALT_TMPL) begin
            alt_d = merge(alt_q, wdata_q, wstrb_q);
        end
        if (wr_fire && awaddr_q == `REG_WAKE_MASK) begin
            msk_d = merge(msk_q, wdata_q, wstrb_q);
        end
        if (ctrl_wr) begin
            cpu_off_d = wdata_q[`CTRL_CPU_OFF];
        end
        // A wakeup in the same cycle as a CPU-off write wins
        if (wake_any) begin
            cpu_off_d = 1'b0;
        end
    end

    // Device reset restores the templates, wake mask and CPU-off flag to their reset values
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_q     <= ACT_RST;
            alt_q     <= ALT_RST;
            msk_q     <= MSK_RST;
            cpu_off_q <= 1'b0;
        end else begin
            act_q     <= act_d;
            alt_q     <= alt_d;
            msk_q     <= msk_d;
            cpu_off_q <= cpu_off_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    logic        irq_wake_en;
    logic        tmr_start;
    logic [11:0] tmr_load;
    logic        tmr_done;

    assign irq_wake_en = |(irq_wake & msk_q[NIRQ-1:0]);
    assign rst_wake    = external_reset_pin || watchdog_reset || precise_supply_reset;
    // Outside hibernate any enabled interrupt, pin or reset wakes
    assign wake_any    = st_q == pwr_pkg::ST_HIB ? pin_interrupt_unit
                       : (irq_wake_en || pin_interrupt_unit || rst_wake);

    always_comb begin
        st_d      = st_q;
        tmr_start = 1'b0;
        tmr_load  = SLP_CYC;
        case (st_q)
            pwr_pkg::ST_ACTIVE: begin
                if (req_pulse == `REQ_ALT) begin
                    st_d = pwr_pkg::ST_ALT;
                end else if (req_pulse == `REQ_SLEEP) begin
                    st_d = pwr_pkg::ST_SLEEP;
                end else if (req_pulse == `REQ_HIB) begin
                    st_d = pwr_pkg::ST_HIB;
                end
            end
            pwr_pkg::ST_ALT: begin
                // Low-power requests from here go back through active first
                if (wake_any || req_pulse != 3'h0) begin
                    st_d = pwr_pkg::ST_ACTIVE;
                end
            end
            pwr_pkg::ST_SLEEP: begin
                if (wake_any) begin
                    st_d      = pwr_pkg::ST_RESUME;
                    tmr_start = 1'b1;
                    // Load and final zero count both take a cycle: active lands on cycle SLP_CYC
                    tmr_load  = SLP_CYC - 12'h2;
                end
            end
            pwr_pkg::ST_HIB: begin
                if (wake_any) begin
                    st_d      = pwr_pkg::ST_RESUME;
                    tmr_start = 1'b1;
                    tmr_load  = HIB_CYC - 12'h2;
                end
            end
            pwr_pkg::ST_RESUME: begin
                if (tmr_done) begin
                    st_d = pwr_pkg::ST_ACTIVE;
                end
            end
            default: st_d = pwr_pkg::ST_ACTIVE;
        endcase
    end

    // Boot into active
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= pwr_pkg::ST_ACTIVE;
        end else begin
            st_q <= st_d;
        end
    end

    // Regulator settle delay before active is entered again
    wake_timer #(.W(12)) u_wake_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (tmr_start),
        .load    (tmr_load),
        .done    (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Subsystem outputs

    logic [NSUB-1:0] en_d, en_q;
    logic            cpu_d, cpu_q;

    // Sleep and hibernate override templates; CPU is template bit 0 gated by its own off flag
    always_comb begin
        case (st_q)
            pwr_pkg::ST_ACTIVE: en_d = act_q[NSUB-1:0];
            pwr_pkg::ST_ALT:    en_d = alt_q[NSUB-1:0];
            pwr_pkg::ST_SLEEP:  en_d = KEEP[NSUB-1:0];
            default:            en_d = '0;
        endcase
        cpu_d = 1'b0;
        if (st_q == pwr_pkg::ST_ACTIVE || st_q == pwr_pkg::ST_ALT) begin
            cpu_d = en_d[`CPU_BIT] && !cpu_off_q;
        end
        if (st_d == pwr_pkg::ST_ACTIVE && st_q != pwr_pkg::ST_ACTIVE) begin
            cpu_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_q  <= '0;
            cpu_q <= 1'b0;
        end else begin
            en_q  <= en_d;
            cpu_q <= cpu_d;
        end
    end

    assign sub_enable = en_q;
    assign sub_clk_en = en_q;
    assign cpu_enable = cpu_q;
    assign clocks_run = st_q != pwr_pkg::ST_HIB;
    assign gpio_hold  = st_q == pwr_pkg::ST_HIB;
    assign reg_enable = st_q != pwr_pkg::ST_HIB;
    assign mode_state = st_q;
endmodule : power_mode_controller

//--- pwr_mode_monitor.sv
// Concurrent checks on the power mode controller ports
`timescale 1ns/1ns
`include "pwr_defines.svh"
module pwr_mode_monitor #(
    parameter int NSUB = 8
) (
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            rst,
    // Watched write response valid and wakeup inputs
    input wire logic            s_axi_bvalid,
    input wire logic            pin_interrupt_unit,
    input wire logic            external_reset_pin,
    // Watched outputs
    input wire logic [NSUB-1:0] sub_enable,
    input wire logic [NSUB-1:0] sub_clk_en,
    input wire logic            cpu_enable,
    input wire logic            clocks_run,
    input wire logic            gpio_hold,
    input wire logic            reg_enable,
    input wire logic [4:0]      mode_state
);
    localparam int SLEEP_LIM = 300;
    localparam int HIB_LIM   = 2000;
    logic [11:0] res_cnt_q;
    logic [11:0] res_cnt_d;
    logic        from_hib_q;
    logic        from_hib_d;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Resume length counter; the origin mode picks the bound, so remember it
    always_comb begin
        res_cnt_d = (mode_state == pwr_pkg::ST_RESUME) ? res_cnt_q + 12'h001 : 12'h000;
        from_hib_d = from_hib_q;
        if (mode_state == pwr_pkg::ST_HIB) begin
            from_hib_d = 1'b1;
        end else if (mode_state == pwr_pkg::ST_SLEEP) begin
            from_hib_d = 1'b0;
        end
    end

    // Registers only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            res_cnt_q <= 12'h000;
            from_hib_q <= 1'b0;
        end else begin
            res_cnt_q <= res_cnt_d;
            from_hib_q <= from_hib_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Multi-step behaviours
    sequence s_resume_done;
        mode_state == pwr_pkg::ST_RESUME ##1 mode_state == pwr_pkg::ST_ACTIVE;
    endsequence
    sequence s_sleep_reset;
        mode_state == pwr_pkg::ST_SLEEP && external_reset_pin;
    endsequence

    a_boot_active: assert property ($fell(rst) |-> mode_state == pwr_pkg::ST_ACTIVE)
        else $error("not active after reset release");
    a_clk_gate: assert property (sub_clk_en == sub_enable)
        else $error("clock enables differ from subsystem enables");
    a_hib_freeze: assert property (mode_state == pwr_pkg::ST_HIB |->
        !clocks_run && gpio_hold && !reg_enable) else $error("hibernate outputs wrong");
    a_live_run: assert property (mode_state != pwr_pkg::ST_HIB |->
        clocks_run && !gpio_hold && reg_enable) else $error("run outputs wrong");
    a_hib_only_pin: assert property (mode_state == pwr_pkg::ST_HIB && !pin_interrupt_unit
        |=> mode_state == pwr_pkg::ST_HIB) else $error("left hibernate without pin");
    a_sleep_bound: assert property (mode_state == pwr_pkg::ST_RESUME && !from_hib_q
        |-> res_cnt_q < 12'(SLEEP_LIM - 1)) else $error("sleep resume too long");
    a_hib_bound: assert property (mode_state == pwr_pkg::ST_RESUME && from_hib_q
        |-> res_cnt_q < 12'(HIB_LIM - 2)) else $error("hibernate resume too long");
    a_wake_cpu: assert property (s_resume_done |-> ##[0:1] cpu_enable)
        else $error("cpu not enabled on wakeup");
    a_reset_wake: assert property (s_sleep_reset |=> mode_state == pwr_pkg::ST_RESUME)
        else $error("reset source did not wake sleep");
    a_sleep_off: assert property (mode_state == pwr_pkg::ST_SLEEP &&
        $past(mode_state, 2) == pwr_pkg::ST_SLEEP |->
        (sub_enable & ~NSUB'(`SLEEP_KEEP)) == '0 && !cpu_enable) else $error("sleep left on");
    a_no_low_low: assert property ($past(mode_state) != mode_state &&
        $past(mode_state) inside {pwr_pkg::ST_ALT, pwr_pkg::ST_SLEEP, pwr_pkg::ST_HIB}
        |-> mode_state inside {pwr_pkg::ST_ACTIVE, pwr_pkg::ST_RESUME})
        else $error("low power to low power step");
    a_entry_write: assert property ($past(mode_state) == pwr_pkg::ST_ACTIVE &&
        mode_state inside {pwr_pkg::ST_ALT, pwr_pkg::ST_SLEEP, pwr_pkg::ST_HIB}
        |-> s_axi_bvalid) else $error("mode entered without write");
endmodule : pwr_mode_monitor

//--- wake_source.sv
// Model of the on-chip wakeup and interrupt event sources
`timescale 1ns/1ns
module wake_source #(
    parameter int NIRQ = 8
) (
    // Clock
    input  wire logic       ref_clk,
    // Event lines, all idle low
    output logic [NIRQ-1:0] irq_wake,
    output logic            pin_interrupt_unit,
    output logic            external_reset_pin,
    output logic            watchdog_reset,
    output logic            precise_supply_reset
);
    logic [NIRQ+3:0] lines_q = '0;

    // Raise one line for len cycles; a long len models a slow source
    task automatic fire(input int k, input int len);
        logic [NIRQ+3:0] v;
        v = '0;
        v[k] = 1'b1;
        @(posedge ref_clk);
        lines_q <= lines_q | v;
        repeat (len) @(posedge ref_clk);
        lines_q <= lines_q & ~v;
    endtask : fire

    // Index NIRQ is the pin interrupt, the three above it are reset sources
    assign {precise_supply_reset, watchdog_reset, external_reset_pin,
            pin_interrupt_unit, irq_wake} = lines_q;
endmodule : wake_source

//--- testbench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
`include "pwr_defines.svh"
module testbench;
    localparam int NSUB = 8;
    localparam int NIRQ = 8;
    logic ref_clk = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NIRQ-1:0] irq_wake;
    logic pin_interrupt_unit, external_reset_pin, watchdog_reset, precise_supply_reset;
    logic [NSUB-1:0] sub_enable, sub_clk_en;
    logic cpu_enable, clocks_run, gpio_hold, reg_enable;
    logic [4:0] mode_state;
    int err_total = 0;
    int n_checks = 0;
    int seed = 32'h0f73920c;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];

    power_mode_controller #(.NSUB(NSUB), .NIRQ(NIRQ)) dut_u (.ref_clk, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_wake, .pin_interrupt_unit, .external_reset_pin,
        .watchdog_reset, .precise_supply_reset, .sub_enable, .sub_clk_en, .cpu_enable,
        .clocks_run, .gpio_hold, .reg_enable, .mode_state);
    wake_source #(.NIRQ(NIRQ)) src_u (.ref_clk, .irq_wake, .pin_interrupt_unit,
        .external_reset_pin, .watchdog_reset, .precise_supply_reset);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    always #25 ref_clk = ~ref_clk;

    // Compare one observed value with its expectation
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bus answers are matched against the oldest note of their channel
    always @(posedge ref_clk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        end
    end

    // Write with address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        exp_b.push_back(r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    // Read one word; the watcher compares data and response
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_r.push_back({r, d});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // Let registered outputs land before looking at them
    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : settle

    // Count edges until the mode shows up; bounded so a stuck mode cannot hang
    task automatic wait_mode(input logic [4:0] m, output int n);
        n = 0;
        while (mode_state !== m && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : wait_mode

    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        int idx;
        logic [31:0] v;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        settle(2);
        chk(mode_state, pwr_pkg::ST_ACTIVE);
        chk(sub_enable, 8'hff);
        axi_rd(`REG_ACT_TMPL, `ACT_TMPL_RST, 2'h0);
        axi_rd(`REG_ALT_TMPL, `ALT_TMPL_RST, 2'h0);
        axi_rd(`REG_WAKE_MASK, `WAKE_MASK_RST, 2'h0);
        axi_rd(12'h014, 32'h0, 2'h2);
        axi_wr(12'h014, 32'h0, 2'h2);
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            axi_wr(`REG_ACT_TMPL, v, 2'h0);
            settle(2);
            chk(sub_enable, v[NSUB-1:0]);
            chk(sub_clk_en, v[NSUB-1:0]);
            chk(cpu_enable, v[`CPU_BIT]);
        end
        axi_wr(`REG_ACT_TMPL, `ACT_TMPL_RST, 2'h0);
        v = $random(seed);
        axi_wr(`REG_ALT_TMPL, v, 2'h0);
        axi_wr(`REG_CTRL, {29'h0, `REQ_ALT}, 2'h0);
        settle(2);
        chk(mode_state, pwr_pkg::ST_ALT);
        chk(sub_enable, v[NSUB-1:0]);
        axi_wr(`REG_CTRL, {29'h0, `REQ_ALT}, 2'h0);
        settle(2);
        chk(mode_state, pwr_pkg::ST_ACTIVE);
        // Cpu switches itself off, an interrupt brings it back
        axi_wr(`REG_CTRL, 32'h10, 2'h0);
        settle(2);
        chk(cpu_enable, 1'b0);
        axi_rd(`REG_CTRL, 32'h10, 2'h0);
        src_u.fire(0, 2);
        settle(2);
        chk(cpu_enable, 1'b1);
        chk(mode_state, pwr_pkg::ST_ACTIVE);
        // A masked interrupt must not wake sleep
        axi_wr(`REG_WAKE_MASK, 32'h0, 2'h0);
        axi_wr(`REG_CTRL, {29'h0, `REQ_SLEEP}, 2'h0);
        src_u.fire(3, 2);
        settle(4);
        chk(mode_state, pwr_pkg::ST_SLEEP);
        axi_wr(`REG_WAKE_MASK, `WAKE_MASK_RST, 2'h0);
        // Each wake source in turn, prompt and slow
        for (int k = 0; k < 5; k++) begin
            axi_wr(`REG_CTRL, {27'h0, k == 4, 1'b0, `REQ_SLEEP}, 2'h0);
            settle(3);
            chk(mode_state, pwr_pkg::ST_SLEEP);
            chk(sub_enable & ~NSUB'(`SLEEP_KEEP), 8'h00);
            chk(cpu_enable, 1'b0);
            axi_wr(`REG_CTRL, {29'h0, `REQ_HIB}, 2'h0);
            settle(2);
            chk(mode_state, pwr_pkg::ST_SLEEP);
            idx = (k == 0) ? {$random(seed)} % NIRQ : NIRQ + k - 1;
            fork
                src_u.fire(idx, k * 3 + 1);
            join_none
            wait_mode(pwr_pkg::ST_ACTIVE, n);
            chk(n <= 302, 1'b1);
            chk(cpu_enable, 1'b1);
        end
        axi_wr(`REG_CTRL, {29'h0, `REQ_HIB}, 2'h0);
        settle(2);
        chk(mode_state, pwr_pkg::ST_HIB);
        chk({clocks_run, gpio_hold, reg_enable}, 3'b010);
        for (int k = 0; k < 4; k++) begin
            src_u.fire((k == 0) ? 0 : NIRQ + k, 3);
            settle(2);
            chk(mode_state, pwr_pkg::ST_HIB);
        end
        fork
            src_u.fire(NIRQ, 2);
        join_none
        wait_mode(pwr_pkg::ST_ACTIVE, n);
        chk(n <= 2001, 1'b1);
        chk(cpu_enable, 1'b1);
        axi_rd(`REG_ACT_TMPL, `ACT_TMPL_RST, 2'h0);
        axi_rd(`REG_STATUS, {27'h0, pwr_pkg::ST_ACTIVE}, 2'h0);
        settle(2);
        final_report();
    end

    // The run needs under 4000 cycles; 10000 cycles means a hang
    initial begin
        #(50 * 10000);
        err_total++;
        final_report();
    end
endmodule : testbench

bind power_mode_controller pwr_mode_monitor #(.NSUB(NSUB)) mon_u (.ref_clk, .rst,
    .s_axi_bvalid, .pin_interrupt_unit, .external_reset_pin, .sub_enable, .sub_clk_en,
    .cpu_enable, .clocks_run, .gpio_hold, .reg_enable, .mode_state);
